// [rtl/asscfg_pkg.sv]
// package for the step 13 configuration register of the auxiliary converter sequencer
package asscfg_pkg;
	localparam logic [7:0] ASSCFG_STEP13_ADDR = 8'h9D;
	localparam int ASSCFG_EN_BIT = 15;
	localparam int ASSCFG_GAIN_HI = 14;
	localparam int ASSCFG_GAIN_LO = 13;
	localparam int ASSCFG_NEG_BIT = 4;
	localparam int ASSCFG_POS_HI = 3;
	localparam int ASSCFG_POS_LO = 0;
	localparam logic ASSCFG_EN_RST = 1'h0;
	localparam logic [1:0] ASSCFG_GAIN_RST = 2'h0;
	localparam logic ASSCFG_NEG_RST = 1'h0;
	localparam logic [3:0] ASSCFG_POS_RST = 4'hD;
	localparam logic [7:0] ASSCFG_RSVD_VAL = 8'h00;
	localparam logic [3:0] ASSCFG_POS_INTERNAL_MIN = 4'h8;
	localparam logic [3:0] ASSCFG_POS_TEMP = 4'h8;
	localparam logic [3:0] ASSCFG_POS_SHORT = 4'h9;
	localparam logic [3:0] ASSCFG_POS_DAC = 4'hA;
	localparam logic [3:0] ASSCFG_STEP_ID = 4'hD;
	typedef enum logic [1:0]
	{
		ASSCFG_GAIN_X1 = 2'h0,
		ASSCFG_GAIN_X2 = 2'h1,
		ASSCFG_GAIN_X4 = 2'h2
	} asscfg_gain_t;
endpackage : asscfg_pkg

// [rtl/asscfg_step13.sv]
// step 13 configuration register with decoded outputs for the sequencer
// Summary of operation
// - bit 15 enables step thirteen, resets zero
// - bits 14:13 gain: 1, 2, 4, 4
// - bits 12:5 always read as zero
// - bit 4 negative: ground or input 7
// - codes 0 to 7 select inputs 0-7
// - internal codes pick negative input automatically
// - 1000b temperature sensor, 1010b test DAC
// - 1001b shorts converter input to ground
// - codes 1100b to 1111b select supply monitors
// - positive select resets to 1101b, others zero
`timescale 1ns/1ps
module asscfg_step13
	import asscfg_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	input wire logic [3:0] seq_step_i,
	output logic step_enable_bit_o,
	output logic [1:0] step_gain_select_o,
	output logic step_negative_input_select_o,
	output logic [3:0] step_positive_input_select_o,
	output logic step_active_o,
	output logic step_skip_o,
	output logic [2:0] gain_factor_o,
	output logic neg_auto_o,
	output logic neg_input7_o,
	output logic [3:0] pos_apply_o
);
	logic en_q;
	logic [1:0] gain_q;
	logic neg_q;
	logic [3:0] pos_q;
	logic wr_hit;
	logic is_step;
	logic auto_neg;

	////////////////////////////////////////////////////////////////////////////////
	// register storage
	assign wr_hit = reg_wr_i && (reg_addr_i == ASSCFG_STEP13_ADDR);

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			en_q <= ASSCFG_EN_RST;
			gain_q <= ASSCFG_GAIN_RST;
			neg_q <= ASSCFG_NEG_RST;
			pos_q <= ASSCFG_POS_RST;
		end
		else if (wr_hit)
		begin
			en_q <= reg_wdata_i[ASSCFG_EN_BIT];
			gain_q <= reg_wdata_i[ASSCFG_GAIN_HI:ASSCFG_GAIN_LO];
			neg_q <= reg_wdata_i[ASSCFG_NEG_BIT];
			pos_q <= reg_wdata_i[ASSCFG_POS_HI:ASSCFG_POS_LO];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			reg_rdata_o <= 16'h0000;
		else if (reg_addr_i == ASSCFG_STEP13_ADDR)
			reg_rdata_o <= {en_q, gain_q, ASSCFG_RSVD_VAL, neg_q, pos_q};
		else
			reg_rdata_o <= 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// field outputs and decode for the sequencer
	assign step_enable_bit_o = en_q;
	assign step_gain_select_o = gain_q;
	assign step_negative_input_select_o = neg_q;
	assign step_positive_input_select_o = pos_q;

	assign is_step = (seq_step_i == ASSCFG_STEP_ID);
	assign step_active_o = is_step && en_q;
	assign step_skip_o = is_step && !en_q;
	assign auto_neg = (pos_q >= ASSCFG_POS_INTERNAL_MIN);

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			gain_factor_o <= 3'h0;
			neg_auto_o <= 1'h0;
			neg_input7_o <= 1'h0;
			pos_apply_o <= 4'h0;
		end
		else if (is_step && en_q)
		begin
			case (gain_q)
				ASSCFG_GAIN_X1: gain_factor_o <= 3'h1;
				ASSCFG_GAIN_X2: gain_factor_o <= 3'h2;
				default: gain_factor_o <= 3'h4;
			endcase
			neg_auto_o <= auto_neg;
			neg_input7_o <= neg_q && !auto_neg;
			pos_apply_o <= pos_q;
		end
		else
		begin
			gain_factor_o <= 3'h0;
			neg_auto_o <= 1'h0;
			neg_input7_o <= 1'h0;
			pos_apply_o <= 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	property p_reset_value;
		@(posedge clk_i) srst_i |=> (pos_q == ASSCFG_POS_RST) && (en_q == ASSCFG_EN_RST) && (gain_q == ASSCFG_GAIN_RST)
			&& (neg_q == ASSCFG_NEG_RST);
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("bad reset value");

	property p_rsvd_zero;
		@(posedge clk_i) disable iff (srst_i) reg_rdata_o[12:5] == ASSCFG_RSVD_VAL;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

	sequence s_write;
		wr_hit;
	endsequence
	property p_en_write;
		@(posedge clk_i) disable iff (srst_i) s_write ##0 !srst_i |=> en_q == $past(reg_wdata_i[ASSCFG_EN_BIT]);
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable not stored");

	property p_pos_write;
		@(posedge clk_i) disable iff (srst_i) s_write |=> pos_q == $past(reg_wdata_i[ASSCFG_POS_HI:ASSCFG_POS_LO]);
	endproperty
	a_pos_write: assert property (p_pos_write) else $error("positive select not stored");

	property p_gain_map;
		@(posedge clk_i) disable iff (srst_i) (is_step && en_q && gain_q[1]) |=> gain_factor_o == 3'h4;
	endproperty
	a_gain_map: assert property (p_gain_map) else $error("gain 4 not applied");

	property p_auto_neg;
		@(posedge clk_i) disable iff (srst_i) (is_step && en_q && pos_q[3]) |=> neg_auto_o && !neg_input7_o;
	endproperty
	a_auto_neg: assert property (p_auto_neg) else $error("negative select not overridden");

	property p_neg_ext;
		@(posedge clk_i) disable iff (srst_i) (is_step && en_q && !pos_q[3]) |=> neg_input7_o == $past(neg_q);
	endproperty
	a_neg_ext: assert property (p_neg_ext) else $error("negative select wrong");

	property p_skip;
		@(posedge clk_i) disable iff (srst_i) (is_step && !en_q) |-> step_skip_o ##1 (pos_apply_o == 4'h0);
	endproperty
	a_skip: assert property (p_skip) else $error("disabled step not skipped");

	sequence s_active;
		is_step && en_q;
	endsequence
	sequence s_idle;
		!(is_step && en_q);
	endsequence

	property p_gain_write;
		@(posedge clk_i) disable iff (srst_i) s_write |=> gain_q == $past(reg_wdata_i[ASSCFG_GAIN_HI:ASSCFG_GAIN_LO]);
	endproperty
	a_gain_write: assert property (p_gain_write) else $error("gain select not stored");

	property p_neg_write;
		@(posedge clk_i) disable iff (srst_i) s_write |=> neg_q == $past(reg_wdata_i[ASSCFG_NEG_BIT]);
	endproperty
	a_neg_write: assert property (p_neg_write) else $error("negative select not stored");

	property p_hold;
		@(posedge clk_i) disable iff (srst_i) !wr_hit |=> $stable({en_q, gain_q, neg_q, pos_q});
	endproperty
	a_hold: assert property (p_hold) else $error("fields changed without a write");

	property p_gain_x1;
		@(posedge clk_i) disable iff (srst_i) s_active ##0 (gain_q == ASSCFG_GAIN_X1) |=> gain_factor_o == 3'h1;
	endproperty
	a_gain_x1: assert property (p_gain_x1) else $error("gain 1 not applied");

	property p_gain_x2;
		@(posedge clk_i) disable iff (srst_i) s_active ##0 (gain_q == ASSCFG_GAIN_X2) |=> gain_factor_o == 3'h2;
	endproperty
	a_gain_x2: assert property (p_gain_x2) else $error("gain 2 not applied");

	property p_pos_apply;
		@(posedge clk_i) disable iff (srst_i) s_active |=> pos_apply_o == $past(pos_q);
	endproperty
	a_pos_apply: assert property (p_pos_apply) else $error("positive select not applied");

	property p_ext_manual;
		@(posedge clk_i) disable iff (srst_i) s_active ##0 (pos_q < ASSCFG_POS_INTERNAL_MIN) |=> !neg_auto_o;
	endproperty
	a_ext_manual: assert property (p_ext_manual) else $error("external input got automatic negative");

	property p_internal_codes;
		@(posedge clk_i) disable iff (srst_i) s_active ##0 ((pos_q == ASSCFG_POS_TEMP) || (pos_q == ASSCFG_POS_SHORT)
			|| (pos_q == ASSCFG_POS_DAC)) |=> neg_auto_o && !neg_input7_o;
	endproperty
	a_internal_codes: assert property (p_internal_codes) else $error("internal source not automatic");

	property p_idle_outputs;
		@(posedge clk_i) disable iff (srst_i) s_idle |=> (gain_factor_o == 3'h0) && !neg_auto_o && !neg_input7_o
			&& (pos_apply_o == 4'h0);
	endproperty
	a_idle_outputs: assert property (p_idle_outputs) else $error("selections applied outside step");

	property p_active_flag;
		@(posedge clk_i) disable iff (srst_i) s_active |-> step_active_o && !step_skip_o;
	endproperty
	a_active_flag: assert property (p_active_flag) else $error("enabled step not active");

	property p_read_back;
		@(posedge clk_i) disable iff (srst_i) (reg_addr_i == ASSCFG_STEP13_ADDR) |=>
			reg_rdata_o == {$past(en_q), $past(gain_q), ASSCFG_RSVD_VAL, $past(neg_q), $past(pos_q)};
	endproperty
	a_read_back: assert property (p_read_back) else $error("read data differs from fields");

	property p_read_other;
		@(posedge clk_i) disable iff (srst_i) (reg_addr_i != ASSCFG_STEP13_ADDR) |=> reg_rdata_o == 16'h0000;
	endproperty
	a_read_other: assert property (p_read_other) else $error("other address read not zero");
endmodule : asscfg_step13

// [tb/asscfg_step13_bench.sv]
// self-checking bench for the step 13 configuration register
`timescale 1ns/1ps
module asscfg_step13_bench;
	import asscfg_pkg::*;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [3:0] seq_step_i = 4'h0;
	logic [15:0] reg_rdata_o;
	logic en_o, neg_o, act_o, skip_o, auto_o, n7_o;
	logic [1:0] gain_o;
	logic [2:0] gf_o;
	logic [3:0] pos_o, papp_o;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	int i;
	asscfg_step13 asscfg_step13_inst (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .seq_step_i(seq_step_i), .step_enable_bit_o(en_o),
		.step_gain_select_o(gain_o), .step_negative_input_select_o(neg_o), .step_positive_input_select_o(pos_o),
		.step_active_o(act_o), .step_skip_o(skip_o), .gain_factor_o(gf_o), .neg_auto_o(auto_o),
		.neg_input7_o(n7_o), .pos_apply_o(papp_o));
	initial forever #12.5 clk_i = ~clk_i;
////////////////////////////////////////////////////////////////////////////////
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task ck(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : ck
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wr_i <= 1'b1;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		@(posedge clk_i);
		@(negedge clk_i);
		ck(reg_rdata_o, e);
	endtask : rd
	// write, select a step, then compare the decoded sequencer outputs
	task ap(input logic [15:0] d, input logic [3:0] s, input logic [10:0] e);
		wr(ASSCFG_STEP13_ADDR, d);
		@(posedge clk_i);
		seq_step_i <= s;
		@(posedge clk_i);
		@(negedge clk_i);
		ck({5'h00, act_o, skip_o, gf_o, auto_o, n7_o, papp_o}, {5'h00, e});
	endtask : ap
////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 600)
		begin
			miscompares++;
			summarize();
		end
	end
	initial
	begin
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
		rd(ASSCFG_STEP13_ADDR, 16'h000D);
		ck({8'h00, en_o, gain_o, neg_o, pos_o}, 16'h000D);
		wr(ASSCFG_STEP13_ADDR, 16'hFFFF);
		rd(ASSCFG_STEP13_ADDR, 16'hE01F);
		ck({8'h00, en_o, gain_o, neg_o, pos_o}, 16'h00FF);
		wr(8'h9C, 16'h0000);
		rd(ASSCFG_STEP13_ADDR, 16'hE01F);
		rd(8'h9C, 16'h0000);
		for (i = 0; i < 4; i++)
			ap({1'b1, i[1:0], 13'h0003}, 4'hD, {2'b10, (i == 0) ? 3'h1 : (i == 1) ? 3'h2 : 3'h4, 2'b00, 4'h3});
		for (i = 0; i < 16; i++)
			ap({8'h80, 3'h1, 1'b1, i[3:0]}, 4'hD, {2'b10, 3'h1, i >= 8, i < 8, i[3:0]});
		ap(16'h0015, 4'hD, {2'b01, 3'h0, 2'b00, 4'h0});
		ap(16'h8015, 4'hC, 11'h000);
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		rd(ASSCFG_STEP13_ADDR, 16'h000D);
		ck({8'h00, en_o, gain_o, neg_o, pos_o}, 16'h000D);
		summarize();
	end
endmodule : asscfg_step13_bench
